/* File: core/dwtw_slave.sv */
// Two-wire slave port for a dual wiper potentiometer.
// Assumes a bus master drives the clock line; data line is open drain.
//
// Notes on behaviour
// [R1] Slave only: never drives the clock line, never makes start or stop.
// [R2] Data falling while clock high is a start.
// [R3] Data rising while clock high is a stop.
// [R4] Data changes only while clock low; one bit per clock pulse.
// [R5] Bytes of eight bits, each followed by receiver acknowledge.
// [R6] Works with bus clocks up to 400 kHz.
// [R7] Acknowledge holds data low across the whole ninth clock high.
// [R8] After master not-acknowledge, slave releases data line.
// [R9] Command byte: control code, three select bits, direction bit.
// [R10] Respond only when select bits equal the select pins.
// [R11] Direction one reads, zero writes.
// [R12] Acknowledge command only on code and select match.
// [R13] All bytes shift most significant bit first.
// [R14] The receiver of a byte generates its acknowledge.
// [R15] Read returns wiper 0 then wiper 1.
// [R16] Master acknowledges to continue, or not-acknowledges and stops.
// [R17] Master writes: start, command with direction zero, then data.
// [R18] Slave acknowledges every written data byte.
// [R19] Repeated start restarts command decoding.
// [R20] Master starts only when both lines are high.
// [R21] Byte count per transfer is unlimited by the device.
// [R22] Data byte select code 01 picks wiper 1, else wiper 0.
// [R23] Bus lines ignored while port enable is high.
// [R24] Both wipers reset to tap 33.
// [R25] Each wiper is a six-bit register.
// [R26] Mismatched command: stay released until next start.
// [R27] Data byte: select in bits 7:6, value in bits 5:0.
`timescale 1ns/100ps
`default_nettype none
module dwtw_slave (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic port_en_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic dev_sel_pin_0,
  input wire logic dev_sel_pin_1,
  input wire logic dev_sel_pin_2,
  output logic [dwtw_pkg::DWTW_WIPER_W-1:0] wiper0,
  output logic [dwtw_pkg::DWTW_WIPER_W-1:0] wiper1,
  output logic busy
);
  import dwtw_pkg::*;

  // Clock must oversample the fast bus rate
  initial begin
    if (DWTW_CLK_KHZ / DWTW_FAST_KHZ < DWTW_MIN_OVERSAMPLE) // R6
      $error("system clock too slow for fast bus mode");
  end

  typedef struct packed {
    dwtw_state_t st;
    logic seen;
    logic pe1;
    logic pe2;
    logic [7:0] sh;
    logic [2:0] cnt;
    logic rd_sel;
    logic oe;
    logic wr;
    logic [7:0] wr_byte;
    logic busy;
    logic [DWTW_WIPER_W-1:0] w0;
    logic [DWTW_WIPER_W-1:0] w1;
  } dwtw_top_st_t;

  dwtw_top_st_t st_q;
  dwtw_top_st_t st_d;
  dwtw_bus_t pins;
  dwtw_bus_t line;
  dwtw_event_t ev;
  logic srst_n;
  logic [2:0] dsel;
  logic [DWTW_WIPER_W-1:0] pot0;
  logic [DWTW_WIPER_W-1:0] pot1;
  logic [7:0] tx_byte;
  // Reset release synchroniser, kept apart since it runs on the raw reset
  logic [1:0] rsync_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end

  assign srst_n = rsync_q[1];
  assign pins = '{scl: scl_in, sda: sda_in};
  assign dsel = {dev_sel_pin_2, dev_sel_pin_1, dev_sel_pin_0};

  dwtw_sync u_sync (
    .clk(mclk),
    .rst_n(srst_n),
    .en_n(port_en_n),
    .pin_in(pins),
    .line(line),
    .ev(ev)
  );

  dwtw_wipers #(.WIDTH(DWTW_WIPER_W)) u_wipers (
    .clk(mclk),
    .rst_n(srst_n),
    .wr(st_q.wr),
    .wr_byte(st_q.wr_byte),
    .pot0(pot0),
    .pot1(pot1)
  );

  // Wiper byte read back: select field names the pot, low bits its value
  assign tx_byte = st_q.rd_sel ? {DWTW_SEL_POT1, pot1} : {2'h0, pot0}; // R27

  always_comb begin
    st_d = st_q;
    st_d.wr = 1'b0;
    st_d.w0 = pot0;
    st_d.w1 = pot1;
    // Port enable pin passes two flops before it gates the data driver
    st_d.pe1 = port_en_n;
    st_d.pe2 = st_q.pe1;
    if (ev.start) begin
      // Start or repeated start restarts decoding
      st_d.st = DWTW_CMD; // R19
      st_d.cnt = 3'h0;
      st_d.seen = 1'b0;
      st_d.oe = 1'b0;
      st_d.busy = 1'b1;
    end else if (ev.stop) begin
      st_d.st = DWTW_IDLE; // R3
      st_d.oe = 1'b0;
      st_d.busy = 1'b0;
    end else begin
      case (st_q.st)
        DWTW_IDLE, DWTW_IGNORE: begin
          st_d.oe = 1'b0; // R26
        end
        DWTW_CMD, DWTW_WR_DATA: begin
          if (ev.rise) begin
            st_d.sh = {st_q.sh[6:0], line.sda}; // R13
            st_d.seen = 1'b1;
          end
          // The clock fall that ends a start carries no bit: not counted
          if (ev.fall && st_q.seen) begin
            st_d.seen = 1'b0;
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt == 3'h7) begin
              if (st_q.st == DWTW_WR_DATA) begin
                st_d.oe = 1'b1; // R18
                st_d.wr = 1'b1;
                st_d.wr_byte = st_q.sh;
                st_d.st = DWTW_WR_ACK;
              end else if (st_q.sh[DWTW_CODE_MSB:DWTW_DSEL_LSB] ==
                           {DWTW_CTRL_CODE, dsel}) begin // R9 R10
                st_d.oe = 1'b1; // R12
                st_d.st = DWTW_CMD_ACK;
              end else begin
                st_d.st = DWTW_IGNORE; // R26
              end
            end
          end
        end
        DWTW_CMD_ACK: begin
          // Acknowledge held through the ninth clock high; on fall released for a write, first data bit driven for a read
          if (ev.fall) begin // R7
            st_d.cnt = 3'h0;
            if (st_q.sh[DWTW_RW_BIT]) begin // R11
              st_d.st = DWTW_RD_DATA;
              st_d.rd_sel = 1'b0; // R15
              st_d.oe = ~tx_byte[7];
            end else begin
              st_d.st = DWTW_WR_DATA;
              st_d.oe = 1'b0;
            end
          end
        end
        DWTW_WR_ACK: begin
          if (ev.fall) begin // R21
            st_d.oe = 1'b0;
            st_d.cnt = 3'h0;
            st_d.st = DWTW_WR_DATA;
          end
        end
        DWTW_RD_DATA: begin
          // Shift out on falling clock edges only
          if (ev.fall) begin // R4
            st_d.cnt = st_q.cnt + 3'h1;
            if (st_q.cnt == 3'h7) begin
              st_d.oe = 1'b0; // R14
              st_d.st = DWTW_RD_ACK;
            end else begin
              st_d.oe = ~tx_byte[3'h6 - st_q.cnt]; // R13
            end
          end
        end
        DWTW_RD_ACK: begin
          if (ev.rise) begin
            if (line.sda) begin
              st_d.st = DWTW_IGNORE; // R8
            end else begin
              st_d.rd_sel = ~st_q.rd_sel; // R15
            end
          end
          if (ev.fall && st_q.st == DWTW_RD_ACK) begin // R5
            st_d.cnt = 3'h0;
            st_d.st = DWTW_RD_DATA;
            st_d.oe = ~tx_byte[7];
          end
        end
        default: begin
          st_d.st = DWTW_IDLE;
          st_d.oe = 1'b0;
        end
      endcase
    end
    // Bus released whenever the port is disabled
    if (st_q.pe2) begin
      st_d.oe = 1'b0; // R23
    end
  end

  always_ff @(posedge mclk or negedge srst_n) begin
    if (!srst_n) begin
      st_q <= '{st: DWTW_IDLE, seen: 1'b0, pe1: 1'b1, pe2: 1'b1,
                sh: 8'h00, cnt: 3'h0, rd_sel: 1'b0, oe: 1'b0, wr: 1'b0,
                wr_byte: 8'h00, busy: 1'b0, w0: DWTW_WIPER_RST,
                w1: DWTW_WIPER_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // Open drain: only ever pulls low; clock line has no driver at all
  assign sda_out = 1'b0; // R1
  assign sda_oe = st_q.oe;
  assign wiper0 = st_q.w0;
  assign wiper1 = st_q.w1;
  assign busy = st_q.busy;

endmodule : dwtw_slave
`default_nettype wire

/* File: include/dwtw_pkg.sv */
// Package for the dual wiper two-wire slave: bus constants and state types.
// Assumes a 250 MHz system clock sampling both bus lines.
package dwtw_pkg;

  localparam logic [3:0] DWTW_CTRL_CODE = 4'h5;
  localparam logic [5:0] DWTW_WIPER_RST = 6'h21;
  localparam int DWTW_WIPER_W = 6;
  // Wiper data byte layout: select in [7:6], value in [5:0]
  localparam int DWTW_SEL_MSB = 7;
  localparam int DWTW_SEL_LSB = 6;
  localparam logic [1:0] DWTW_SEL_POT1 = 2'h1;
  localparam int DWTW_CODE_MSB = 7;
  localparam int DWTW_CODE_LSB = 4;
  localparam int DWTW_DSEL_MSB = 3;
  localparam int DWTW_DSEL_LSB = 1;
  localparam int DWTW_RW_BIT = 0;
  // Fastest bus rate served, and the clock rate
  localparam int DWTW_FAST_KHZ = 400;
  localparam int DWTW_CLK_KHZ = 250000;
  localparam int DWTW_MIN_OVERSAMPLE = 16;

  typedef enum {
    DWTW_IDLE,
    DWTW_CMD,
    DWTW_CMD_ACK,
    DWTW_WR_DATA,
    DWTW_WR_ACK,
    DWTW_RD_DATA,
    DWTW_RD_ACK,
    DWTW_IGNORE
  } dwtw_state_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } dwtw_bus_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } dwtw_event_t;

endpackage : dwtw_pkg

/* File: core/dwtw_sync.sv */
// Two-flop synchroniser for the bus lines plus condition detection.
// Assumes raw pin levels from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module dwtw_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en_n,
  input wire dwtw_pkg::dwtw_bus_t pin_in,
  output dwtw_pkg::dwtw_bus_t line,
  output dwtw_pkg::dwtw_event_t ev
);
  import dwtw_pkg::*;

  typedef struct packed {
    dwtw_bus_t s1;
    dwtw_bus_t s2;
    logic en_n1;
    logic en_n2;
    dwtw_bus_t prev;
    dwtw_event_t ev;
  } dwtw_sync_st_t;

  dwtw_sync_st_t st_q;
  dwtw_sync_st_t st_d;
  dwtw_bus_t cur;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.en_n1 = en_n;
    st_d.en_n2 = st_q.en_n1;
    // Disabled port looks like an idle bus
    cur = st_q.en_n2 ? 2'h3 : st_q.s2; // R23
    st_d.prev = cur;
    st_d.ev.start = st_q.prev.scl & cur.scl & st_q.prev.sda & ~cur.sda; // R2
    st_d.ev.stop = st_q.prev.scl & cur.scl & ~st_q.prev.sda & cur.sda; // R3
    st_d.ev.rise = ~st_q.prev.scl & cur.scl;
    st_d.ev.fall = st_q.prev.scl & ~cur.scl;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{s1: 2'h3, s2: 2'h3, en_n1: 1'b1, en_n2: 1'b1,
                prev: 2'h3, ev: 4'h0};
    end else begin
      st_q <= st_d;
    end
  end

  assign line = st_q.prev;
  assign ev = st_q.ev;

endmodule : dwtw_sync
`default_nettype wire

/* File: core/dwtw_wipers.sv */
// Pair of wiper position registers with a byte-wise write port.
// Assumes one-cycle write strobes from the serial engine.
`timescale 1ns/100ps
`default_nettype none
module dwtw_wipers #(
  parameter int WIDTH = dwtw_pkg::DWTW_WIPER_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [7:0] wr_byte,
  output logic [WIDTH-1:0] pot0,
  output logic [WIDTH-1:0] pot1
);
  import dwtw_pkg::*;

  initial begin
    if (WIDTH != DWTW_WIPER_W) $error("wiper width must be 6");
  end

  typedef struct packed {
    logic [WIDTH-1:0] p0;
    logic [WIDTH-1:0] p1;
  } dwtw_wip_st_t;

  dwtw_wip_st_t st_q;
  dwtw_wip_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (wr) begin
      if (wr_byte[DWTW_SEL_MSB:DWTW_SEL_LSB] == DWTW_SEL_POT1) begin // R22
        st_d.p1 = wr_byte[WIDTH-1:0]; // R25
      end else begin
        st_d.p0 = wr_byte[WIDTH-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '{p0: DWTW_WIPER_RST, p1: DWTW_WIPER_RST}; // R24
    end else begin
      st_q <= st_d;
    end
  end

  assign pot0 = st_q.p0;
  assign pot1 = st_q.p1;

endmodule : dwtw_wipers
`default_nettype wire

/* File: verif/dwtw_master.sv */
// Bus master model for the two-wire slave: clock, start, stop, bytes.
// Assumes a pull-up on the data line; the slave only pulls it low.
`timescale 1ns/100ps
`default_nettype none
module dwtw_master (
  input wire logic sda_oe,
  output logic scl,
  output wire logic sda
);
  localparam realtime Q = 31.25;
  logic sda_m = 1'b1;
  initial scl = 1'b1;
  // Pulled-up open drain line
  assign sda = sda_m & ~sda_oe;

  task automatic start;
    #Q sda_m = 1'b1;
    #Q scl = 1'b1;
    #Q sda_m = 1'b0;
    #Q scl = 1'b0;
  endtask : start

  task automatic stop;
    #Q sda_m = 1'b0;
    #Q scl = 1'b1;
    #Q sda_m = 1'b1;
    #Q;
  endtask : stop

  task automatic bitx(input logic b, output logic s);
    #Q sda_m = b;
    #Q scl = 1'b1;
    #Q s = sda;
    #Q scl = 1'b0;
  endtask : bitx

  task automatic xfer(input logic [7:0] d, input logic ack,
                      output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(ack, a);
  endtask : xfer
endmodule : dwtw_master
`default_nettype wire

/* File: verif/dwtw_slave_asserts.sv */
// Checker for the two-wire slave, bound to its top module.
// Assumes one clock domain, rst_n its only reset.
`timescale 1ns/100ps
`default_nettype none
module dwtw_slave_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic port_en_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic [dwtw_pkg::DWTW_WIPER_W-1:0] wiper0,
  input wire logic [dwtw_pkg::DWTW_WIPER_W-1:0] wiper1,
  input wire logic busy
);
  import dwtw_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_out_low; sda_out == 1'b0; endproperty
  a_out_low: assert property (p_out_low) else $error("data high");
  property p_off; port_en_n [*8] |-> !sda_oe; endproperty
  a_off: assert property (p_off) else $error("drives while off");
  property p_oe_edge; $rose(sda_oe) || $fell(sda_oe) |-> !scl_in; endproperty
  a_oe_edge: assert property (p_oe_edge) else $error("edge at high");
  property p_oe_hold; scl_in && $past(scl_in) |-> $stable(sda_oe); endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("data moved");
  property p_bstart; $rose(busy) |-> scl_in && !sda_in; endproperty
  a_bstart: assert property (p_bstart) else $error("busy no start");
  property p_bstop; $fell(busy) |-> scl_in && sda_in; endproperty
  a_bstop: assert property (p_bstop) else $error("idle no stop");
  property p_wchg; $changed(wiper0) || $changed(wiper1) |-> busy && !scl_in;
  endproperty
  a_wchg: assert property (p_wchg) else $error("wiper moved");
  property p_rstv;
    $rose(rst_n) |-> wiper0 == DWTW_WIPER_RST && wiper1 == DWTW_WIPER_RST;
  endproperty
  a_rstv: assert property (p_rstv) else $error("wiper reset");
  property p_oe_busy; sda_oe |-> busy; endproperty
  a_oe_busy: assert property (p_oe_busy) else $error("drive idle");
endmodule : dwtw_slave_asserts
bind dwtw_slave dwtw_slave_asserts dwtw_slave_asserts_inst (.mclk(mclk),
  .rst_n(rst_n), .port_en_n(port_en_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .wiper0(wiper0), .wiper1(wiper1),
  .busy(busy));
`default_nettype wire

/* File: verif/dwtw_slave_tb.sv */
// Self-checking bench for the two-wire slave.
// Assumes the master model drives the bus and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module dwtw_slave_tb;
  import dwtw_pkg::*;
`define CHK(p, q) begin comparisons++; if ((p) !== (q)) begin fails++; \
  $display("BAD %0t %h %h", $time, p, q); end end
  typedef struct packed {
    logic [2:0] s;
    logic [7:0] d;
    logic [5:0] x0;
    logic [5:0] x1;
  } dwtw_row_t;
  dwtw_row_t rows [5] = '{
    '{3'h0, 8'h45, 6'h21, 6'h05}, '{3'h7, 8'h0A, 6'h0A, 6'h05},
    '{3'h5, 8'h80, 6'h00, 6'h05}, '{3'h2, 8'hFF, 6'h3F, 6'h05},
    '{3'h1, 8'h7F, 6'h3F, 6'h3F}};
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic port_en_n = 1'b0;
  logic [2:0] dsel = 3'h5;
  wire scl, sda;
  logic sda_out, sda_oe, busy, a;
  logic [5:0] w0, w1;
  logic [7:0] r;
  int fails = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;

  dwtw_master dwtw_master_inst (.sda_oe(sda_oe), .scl(scl), .sda(sda));
  dwtw_slave dwtw_slave_inst (.mclk(mclk), .rst_n(rst_n),
    .port_en_n(port_en_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dev_sel_pin_0(dsel[0]), .dev_sel_pin_1(dsel[1]),
    .dev_sel_pin_2(dsel[2]), .wiper0(w0), .wiper1(w1), .busy(busy));

  task automatic cmd(input logic [2:0] s, input logic rw, input logic ea);
    dwtw_master_inst.start();
    dwtw_master_inst.xfer({DWTW_CTRL_CODE, s, rw}, 1'b1, r, a);
    `CHK(a, ea)
  endtask : cmd
  task automatic wr(input logic [7:0] d, input logic ea);
    dwtw_master_inst.xfer(d, 1'b1, r, a);
    `CHK(a, ea)
  endtask : wr
  task automatic rd(input logic ma, input logic [7:0] x);
    dwtw_master_inst.xfer(8'hFF, ma, r, a);
    `CHK(r, x)
  endtask : rd
  task automatic report_and_stop;
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (6) @(negedge mclk);
    `CHK({w0, w1}, {DWTW_WIPER_RST, DWTW_WIPER_RST})
    rst_n = 1'b1;
    repeat (12) @(negedge mclk);
    foreach (rows[i]) begin
      dsel = rows[i].s;
      repeat (4) @(negedge mclk);
      cmd(rows[i].s, 1'b0, 1'b0);
      wr(rows[i].d, 1'b0);
      dwtw_master_inst.stop();
      @(negedge mclk);
      `CHK({w0, w1, busy}, {rows[i].x0, rows[i].x1, 1'b0})
    end
    // Two bytes in one write, then a repeated start into a read
    cmd(dsel, 1'b0, 1'b0);
    wr(8'h41, 1'b0);
    wr(8'h12, 1'b0);
    cmd(dsel, 1'b1, 1'b0);
    rd(1'b0, 8'h12);
    rd(1'b1, {DWTW_SEL_POT1, 6'h01});
    repeat (8) @(negedge mclk);
    `CHK(sda_oe, 1'b0)
    dwtw_master_inst.stop();
    cmd(dsel ^ 3'h4, 1'b0, 1'b1);
    wr(8'h00, 1'b1);
    cmd(dsel, 1'b0, 1'b0);
    wr(8'h4A, 1'b0);
    dwtw_master_inst.start();
    dwtw_master_inst.xfer({DWTW_CTRL_CODE ^ 4'h2, dsel, 1'b0}, 1'b1, r, a);
    `CHK(a, 1'b1)
    wr(8'h40, 1'b1);
    dwtw_master_inst.stop();
    `CHK({w0, w1}, {6'h12, 6'h0A})
    @(negedge mclk);
    port_en_n = 1'b1;
    cmd(dsel, 1'b0, 1'b1);
    wr(8'h7F, 1'b1);
    dwtw_master_inst.stop();
    @(negedge mclk);
    port_en_n = 1'b0;
    `CHK(w1, 6'h0A)
    rst_n = 1'b0;
    @(negedge mclk);
    `CHK({w0, w1, busy}, {DWTW_WIPER_RST, DWTW_WIPER_RST, 1'b0})
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    report_and_stop();
  end

  initial begin
    #200000;
    fails++;
    report_and_stop();
  end
endmodule : dwtw_slave_tb
`default_nettype wire
